// [hw/pbl_regs.sv]
// phy management registers: downshift, error tally, self test, status
`timescale 1ns/1ps
//
// Functional notes
// [R01] polarity bit: set means interrupt active low
// [R02] retry code selects 1, 2, 4, 8 failures
// [R03] downshift enable; reset zero or strap
// [R04] energy mode downshifts on silent pairs
// [R05] ten-megabit fallback after gig and 100 fail
// [R06] error tally saturates; any write clears
// [R07] wrap mode: counter max pulses, restarts zero
// [R08] software sets wrap mode before pattern testing
// [R09] payload select: pattern stream or single packet
// [R10] short frame 64 bytes, else 1518
// [R11] generator enable starts and stops generator
// [R12] reverse forward settable only in reverse loop
// [R13] mii forward settable only in mii loop
// [R14] loop point one-hot codes select loopback
// [R15] software clears coding loop before loop change
// [R16] 100 Mb/s coding loop point codes
// [R17] gigabit: low bit loops before signal processing
// [R18] locked bit follows checker lock
// [R19] lock dropped latches, clears on read
// [R20] generator active while generating
// [R21] two scrambler legacy bits, master and slave
// [R22] core power state bit shows normal power
// [R23] latched bit cleared by read returning it
//
module pbl_regs #(
  parameter logic        STRAP_VARIANT = 1'b1, // 1: enable taken from strap
  parameter logic [10:0] GAP_BYTES     = 11'h00C // one less than the idle bytes between packets
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic [4:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  input  wire logic        STRAP_DOWNSHIFT,
  input  wire logic        RX_ERR_EVENT,
  input  wire logic        CHECKER_LOCK,
  input  wire logic        SCR_LEGACY_MASTER,
  input  wire logic        SCR_LEGACY_SLAVE,
  input  wire logic        CORE_NORMAL_POWER,
  input  wire logic        SPEED_GIG,
  input  wire logic        SPEED_100,
  input  wire logic        IRQ_EVENT,
  output logic             IRQ_PIN,
  output logic             GEN_TX_VALID,
  output logic             PAT_WRAP_PULSE,
  output pbl_pkg::pbl_ds_cfg_t DOWNSHIFT_CFG,
  output pbl_pkg::pbl_loop_t   LOOP_CFG
);

  ////////////////////////////////////////////////////////////////////////
  // state
  pbl_pkg::pbl_state_t q;        // registered state
  pbl_pkg::pbl_state_t d;        // next state
  pbl_pkg::pbl_stat_t  pins;     // raw asynchronous inputs
  logic                strap_s1; // strap synchroniser stage one
  logic                strap_s2; // strap synchroniser stage two
  logic                strap_v1; // stage one holds a pin sample
  logic                strap_v2; // stage two holds a pin sample

  assign pins = '{rx_err:    RX_ERR_EVENT,
                  lock:      CHECKER_LOCK,
                  scr_m:     SCR_LEGACY_MASTER,
                  scr_s:     SCR_LEGACY_SLAVE,
                  pwr:       CORE_NORMAL_POWER,
                  speed_gig: SPEED_GIG,
                  speed_100: SPEED_100};

  ////////////////////////////////////////////////////////////////////////
  // strap synchroniser; kept apart so the state struct stays uniform
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      strap_v1 <= 1'b0;
      strap_v2 <= 1'b0;
    end
    else
    begin
      strap_s1 <= STRAP_DOWNSHIFT;
      strap_s2 <= strap_s1;
      // valid marks follow the data, so the reset zero in stage two
      // is never mistaken for a sampled strap level
      strap_v1 <= 1'b1;
      strap_v2 <= strap_v1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    logic        wr_cfg;
    logic        wr_err;
    logic        wr_st;
    logic        rd_ss;
    logic [15:0] st_new;
    logic [15:0] ss_val;
    logic [1:0]  code;
    logic [10:0] frame_len;
    logic        pat_on;
    wr_cfg    = WR && (ADDR == pbl_pkg::ADDR_CONFIG_TWO);
    wr_err    = WR && (ADDR == pbl_pkg::ADDR_RX_ERR);
    wr_st     = WR && (ADDR == pbl_pkg::ADDR_SELF_TEST);
    rd_ss     = RD && (ADDR == pbl_pkg::ADDR_STATUS_TWO);
    st_new    = '0;
    ss_val    = '0;
    code      = 2'h0;
    frame_len = '0;
    pat_on    = 1'b0;
    d         = q;

    // two-stage synchronisers; only stage two is read below
    d.s1 = pins;
    d.s2 = q.s1;
    d.err_prev  = q.s2.rx_err;
    d.lock_prev = q.s2.lock;

    // strap caught once, after reset release
    // [R03] strap-sampled enable
    // wait until stage two carries a real pin sample
    if (!q.strap_done && strap_v2)
    begin
      d.strap_done = 1'b1;
      if (STRAP_VARIANT)
        d.cfg[pbl_pkg::CFG_DS_EN_BIT] = strap_s2;
    end

    // config_two write; reserved bits keep their fixed values
    if (wr_cfg)
      d.cfg = (q.cfg & ~pbl_pkg::CFG_WMASK) | (WDATA & pbl_pkg::CFG_WMASK);

    // [R06] tally saturates, write clears
    if (wr_err)
      d.tally = '0;
    else if (q.s2.rx_err && !q.err_prev && q.tally != pbl_pkg::TALLY_MAX)
      d.tally = q.tally + 16'h0001;

    // self_test_control write with loop-dependent forward bits
    if (wr_st)
    begin
      st_new = (q.st & ~pbl_pkg::ST_WMASK) | (WDATA & pbl_pkg::ST_WMASK);
      // [R12] reverse forward gated
      if (st_new[pbl_pkg::ST_LOOP_LO +: 4] != pbl_pkg::LOOP_REVERSE)
        st_new[pbl_pkg::ST_REV_FWD_BIT] = 1'b0;
      // [R13] mii forward gated
      if (st_new[pbl_pkg::ST_LOOP_LO +: 4] != pbl_pkg::LOOP_DIGITAL)
        st_new[pbl_pkg::ST_MII_FWD_BIT] = 1'b0;
      d.st = st_new;
    end

    // [R19] lock loss latches; set wins over the clearing read
    // [R23] read returning it clears
    if (q.lock_prev && !q.s2.lock)
      d.lost = 1'b1;
    else if (rd_ss)
      d.lost = 1'b0;

    // [R09] pattern path only with payload select
    // [R08] pattern path also needs the wrap mode bit set
    pat_on = q.st[pbl_pkg::ST_PAYLOAD_BIT] && q.st[pbl_pkg::ST_WRAP_BIT];
    // [R10] frame length choice
    frame_len = q.st[pbl_pkg::ST_SHORT_BIT] ? pbl_pkg::FRAME_SHORT
                                            : pbl_pkg::FRAME_LONG;

    // [R11] generator sequencing
    d.tx_valid = 1'b0;
    unique case (q.gen)
      pbl_pkg::GEN_IDLE:
      begin
        d.byte_cnt = '0;
        if (q.st[pbl_pkg::ST_GEN_EN_BIT])
          d.gen = pbl_pkg::GEN_SEND;
      end
      pbl_pkg::GEN_SEND:
      begin
        d.tx_valid = 1'b1;
        d.byte_cnt = q.byte_cnt + 11'h001;
        if (!q.st[pbl_pkg::ST_GEN_EN_BIT])
        begin
          d.gen      = pbl_pkg::GEN_IDLE;
          d.tx_valid = 1'b0;
        end
        else if (q.byte_cnt == frame_len - 11'h001)
        begin
          d.byte_cnt = '0;
          // constant packet: one only, then wait for enable to drop
          d.gen = pbl_pkg::GEN_GAP;
        end
      end
      pbl_pkg::GEN_GAP:
      begin
        d.byte_cnt = q.byte_cnt + 11'h001;
        if (!q.st[pbl_pkg::ST_GEN_EN_BIT])
          d.gen = pbl_pkg::GEN_IDLE;
        else if (pat_on && q.byte_cnt == GAP_BYTES)
        begin
          d.byte_cnt = '0;
          d.gen      = pbl_pkg::GEN_SEND;
        end
        else if (!pat_on)
          d.byte_cnt = '0;
      end
    endcase

    // [R07] pattern counter wraps with pulse
    d.pat_wrap = 1'b0;
    if (pat_on && q.tx_valid)
    begin
      if (q.pat_cnt == pbl_pkg::PAT_MAX)
      begin
        d.pat_cnt  = '0;
        d.pat_wrap = 1'b1;
      end
      else
        d.pat_cnt = q.pat_cnt + 16'h0001;
    end

    // [R01] interrupt pin polarity
    d.irq = IRQ_EVENT ^ q.cfg[pbl_pkg::CFG_INT_POL_BIT];

    // [R02] retry code decode
    unique case (q.cfg[pbl_pkg::CFG_RETRY_LO +: 2])
      2'h0: d.ds.retry_limit = pbl_pkg::RETRY_N0;
      2'h1: d.ds.retry_limit = pbl_pkg::RETRY_N1;
      2'h2: d.ds.retry_limit = pbl_pkg::RETRY_N2;
      2'h3: d.ds.retry_limit = pbl_pkg::RETRY_N3;
    endcase
    d.ds.irq_active_low = q.cfg[pbl_pkg::CFG_INT_POL_BIT];
    // [R03] downshift enable out
    d.ds.downshift_enable = q.cfg[pbl_pkg::CFG_DS_EN_BIT];
    // [R04] energy mode out
    d.ds.downshift_energy_mode_enable = q.cfg[pbl_pkg::CFG_ENERGY_BIT];
    // [R05] ten fallback out
    d.ds.downshift_to_ten_enable = q.cfg[pbl_pkg::CFG_TEN_BIT];

    // [R14] loop point select
    d.lp.loop_point = q.st[pbl_pkg::ST_LOOP_LO +: 4];
    d.lp.rev_fwd    = q.st[pbl_pkg::ST_REV_FWD_BIT];
    d.lp.mii_fwd    = q.st[pbl_pkg::ST_MII_FWD_BIT];
    // [R15] no sequencing check; software orders writes
    code = q.st[1:0];
    // [R16] 100 Mb/s loop points
    d.lp.post_mlt = q.s2.speed_100 && code == pbl_pkg::CODE_LOOP_POST_MLT;
    d.lp.pre_mlt  = q.s2.speed_100 && code == pbl_pkg::CODE_LOOP_PRE_MLT;
    d.lp.pre_scr  = q.s2.speed_100 && code == pbl_pkg::CODE_LOOP_PRE_SCR;
    // [R17] gigabit low bit loop
    d.lp.gig_pre_dsp = q.s2.speed_gig && code[0];

    // status_two assembly
    // [R18] locked bit
    ss_val[pbl_pkg::SS_LOCK_BIT]  = q.s2.lock;
    ss_val[pbl_pkg::SS_LOST_BIT]  = q.lost;
    // [R20] generator active
    ss_val[pbl_pkg::SS_BUSY_BIT]  = (q.gen == pbl_pkg::GEN_SEND);
    // [R21] scrambler legacy bits
    ss_val[pbl_pkg::SS_SCR_M_BIT] = q.s2.scr_m;
    ss_val[pbl_pkg::SS_SCR_S_BIT] = q.s2.scr_s;
    // [R22] core power state
    ss_val[pbl_pkg::SS_PWR_BIT]   = q.s2.pwr;

    // read data valid the cycle after the strobe, zero otherwise
    d.rdata = '0;
    if (RD)
    begin
      unique case (ADDR)
        pbl_pkg::ADDR_CONFIG_TWO: d.rdata = q.cfg;
        pbl_pkg::ADDR_RX_ERR:     d.rdata = q.tally;
        pbl_pkg::ADDR_SELF_TEST:  d.rdata = q.st;
        pbl_pkg::ADDR_STATUS_TWO: d.rdata = ss_val;
        default:                  d.rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; constants only under reset
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      q       <= '0;
      q.cfg   <= pbl_pkg::CFG_RESET;
      q.st    <= pbl_pkg::ST_RESET;
      q.gen   <= pbl_pkg::GEN_IDLE;
      q.irq   <= 1'b0;
      q.ds    <= '{irq_active_low: 1'b1, retry_limit: pbl_pkg::RETRY_N2,
                   downshift_enable: 1'b0,
                   downshift_energy_mode_enable: 1'b1,
                   downshift_to_ten_enable: 1'b1};
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign RDATA          = q.rdata;
  assign IRQ_PIN        = q.irq;
  assign GEN_TX_VALID   = q.tx_valid;
  assign PAT_WRAP_PULSE = q.pat_wrap;
  assign DOWNSHIFT_CFG  = q.ds;
  assign LOOP_CFG       = q.lp;

endmodule // pbl_regs

// [shared/pbl_pkg.sv]
// package: register map, field positions and types for the phy test registers
package pbl_pkg;

  // register addresses (management register index)
  localparam logic [4:0] ADDR_CONFIG_TWO = 5'h14;
  localparam logic [4:0] ADDR_RX_ERR     = 5'h15;
  localparam logic [4:0] ADDR_SELF_TEST  = 5'h16;
  localparam logic [4:0] ADDR_STATUS_TWO = 5'h17;

  // config_two field positions
  localparam int CFG_INT_POL_BIT  = 13;
  localparam int CFG_RETRY_LO     = 10;
  localparam int CFG_DS_EN_BIT    = 9;
  localparam int CFG_ENERGY_BIT   = 8;
  localparam int CFG_TEN_BIT      = 6;
  // writable bits of config_two
  localparam logic [15:0] CFG_WMASK = 16'h2F40;
  // reset value with strap-dependent enable bit clear; low bits read 0 0111
  localparam logic [15:0] CFG_RESET = 16'h2947;

  // self_test_control field positions
  localparam int ST_WRAP_BIT     = 15;
  localparam int ST_PAYLOAD_BIT  = 14;
  localparam int ST_SHORT_BIT    = 13;
  localparam int ST_GEN_EN_BIT   = 12;
  localparam int ST_REV_FWD_BIT  = 7;
  localparam int ST_MII_FWD_BIT  = 6;
  localparam int ST_LOOP_LO      = 2;
  // writable bits of self_test_control: 15:12 and 7:0, 11:8 reserved
  localparam logic [15:0] ST_WMASK = 16'hF0FF;
  localparam logic [15:0] ST_RESET = 16'h0000;

  // status_two field positions
  localparam int SS_LOCK_BIT   = 11;
  localparam int SS_LOST_BIT   = 10;
  localparam int SS_BUSY_BIT   = 9;
  localparam int SS_SCR_M_BIT  = 8;
  localparam int SS_SCR_S_BIT  = 7;
  localparam int SS_PWR_BIT    = 6;

  // loop point codes
  localparam logic [3:0] LOOP_REVERSE  = 4'h8;
  localparam logic [3:0] LOOP_EXTERNAL = 4'h4;
  localparam logic [3:0] LOOP_ANALOG   = 4'h2;
  localparam logic [3:0] LOOP_DIGITAL  = 4'h1;

  // coding-layer loop codes at 100 Mb/s
  localparam logic [1:0] CODE_LOOP_OFF      = 2'h0;
  localparam logic [1:0] CODE_LOOP_PRE_SCR  = 2'h1;
  localparam logic [1:0] CODE_LOOP_PRE_MLT  = 2'h2;
  localparam logic [1:0] CODE_LOOP_POST_MLT = 2'h3;

  // retry count codes and tolerated failures
  localparam logic [3:0] RETRY_N0 = 4'h1;
  localparam logic [3:0] RETRY_N1 = 4'h2;
  localparam logic [3:0] RETRY_N2 = 4'h4;
  localparam logic [3:0] RETRY_N3 = 4'h8;

  // frame lengths in bytes
  localparam logic [10:0] FRAME_SHORT = 11'h040;
  localparam logic [10:0] FRAME_LONG  = 11'h5EE;

  localparam logic [15:0] TALLY_MAX = 16'hFFFF;
  localparam logic [15:0] PAT_MAX   = 16'hFFFF;

  // generator states
  typedef enum logic [1:0] {GEN_IDLE, GEN_SEND, GEN_GAP} pbl_gen_t;

  // decoded controls handed to the datapath
  typedef struct packed {
    logic       irq_active_low;
    logic [3:0] retry_limit;
    logic       downshift_enable;
    logic       downshift_energy_mode_enable;
    logic       downshift_to_ten_enable;
  } pbl_ds_cfg_t;

  typedef struct packed {
    logic       rev_fwd;
    logic       mii_fwd;
    logic [3:0] loop_point;
    logic       post_mlt;
    logic       pre_mlt;
    logic       pre_scr;
    logic       gig_pre_dsp;
  } pbl_loop_t;

  // line-side status inputs after synchronising
  typedef struct packed {
    logic rx_err;
    logic lock;
    logic scr_m;
    logic scr_s;
    logic pwr;
    logic speed_gig;
    logic speed_100;
  } pbl_stat_t;

  // module state, all but the strap synchroniser
  typedef struct packed {
    pbl_stat_t   s1;
    pbl_stat_t   s2;
    logic        err_prev;
    logic        lock_prev;
    logic        strap_done;
    logic [15:0] cfg;
    logic [15:0] st;
    logic [15:0] tally;
    logic        lost;
    logic [15:0] rdata;
    pbl_gen_t    gen;
    logic [10:0] byte_cnt;
    logic [15:0] pat_cnt;
    logic        pat_wrap;
    logic        tx_valid;
    logic        irq;
    pbl_ds_cfg_t ds;
    pbl_loop_t   lp;
  } pbl_state_t;

endpackage

// [verification/pbl_regs_asserts.sv]
// checker: port-level assertions for the phy test register block
`timescale 1ns/1ps
module pbl_regs_chk (
  input wire logic                 CLK_SYS,
  input wire logic                 RST,
  input wire logic [4:0]           ADDR,
  input wire logic [15:0]          WDATA,
  input wire logic                 WR,
  input wire logic                 RD,
  input wire logic [15:0]          RDATA,
  input wire logic                 CHECKER_LOCK,
  input wire logic                 IRQ_EVENT,
  input wire logic                 IRQ_PIN,
  input wire logic                 GEN_TX_VALID,
  input wire pbl_pkg::pbl_ds_cfg_t DOWNSHIFT_CFG,
  input wire pbl_pkg::pbl_loop_t   LOOP_CFG
);
  logic        cw;       // config_two write this cycle
  logic        sw;       // self_test_control write this cycle
  logic [3:0]  ds_w;     // decoded downshift bits seen
  logic [3:0]  wd_w;     // the same bits as written
  logic [5:0]  lo_w;     // loop outputs seen
  logic [5:0]  lw_w;     // loop outputs expected from a write
  logic [2:0]  lock_h_q; // lock history, deeper than the sync chain
  logic [10:0] run_q;    // length of the current transmit burst
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  assign cw = WR && ADDR == pbl_pkg::ADDR_CONFIG_TWO;
  assign sw = WR && ADDR == pbl_pkg::ADDR_SELF_TEST;
  assign ds_w = {DOWNSHIFT_CFG.irq_active_low, DOWNSHIFT_CFG.downshift_enable,
                 DOWNSHIFT_CFG.downshift_energy_mode_enable,
                 DOWNSHIFT_CFG.downshift_to_ten_enable};
  assign wd_w = {WDATA[13], WDATA[9], WDATA[8], WDATA[6]};
  assign lo_w = {LOOP_CFG.rev_fwd, LOOP_CFG.mii_fwd, LOOP_CFG.loop_point};
  // forward bits survive only beside their own loop code
  assign lw_w = {WDATA[7] && WDATA[5:2] == pbl_pkg::LOOP_REVERSE,
                 WDATA[6] && WDATA[5:2] == pbl_pkg::LOOP_DIGITAL, WDATA[5:2]};
  //////////////////////////////////////////////////////////////////////////
  // history reset like the sync flops, so a stale match cannot fire
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
    begin
      lock_h_q <= 3'h0;
      run_q    <= 11'h000;
    end
    else
    begin
      lock_h_q <= {lock_h_q[1:0], CHECKER_LOCK};
      run_q    <= GEN_TX_VALID ? run_q + 11'h001 : 11'h000;
    end
  //////////////////////////////////////////////////////////////////////////
  // polarity must be settled two cycles, either lag path is then covered
  a_irq_polarity:
    assert property (!$past(RST) && $stable(ds_w[3]) &&
      $past(ds_w[3], 2) == ds_w[3] |-> IRQ_PIN == ($past(IRQ_EVENT) ^ ds_w[3]))
    else $error("interrupt pin level wrong");
  a_retry_map:
    assert property (cw ##1 !cw |=> DOWNSHIFT_CFG.retry_limit ==
      4'h1 << $past(WDATA[11:10], 2)) else $error("retry limit wrong");
  a_ds_bits:
    assert property (cw ##1 !cw |=> ds_w == $past(wd_w, 2))
    else $error("downshift bits wrong");
  a_loop_point:
    assert property (sw ##1 !sw |=> lo_w == $past(lw_w, 2))
    else $error("loop outputs wrong");
  a_tally_clear:
    assert property (WR && ADDR == pbl_pkg::ADDR_RX_ERR ##1
      RD && ADDR == pbl_pkg::ADDR_RX_ERR |=> RDATA[15:1] == 15'h0000)
    else $error("tally not cleared");
  a_lock_follow:
    assert property (RD && ADDR == pbl_pkg::ADDR_STATUS_TWO &&
      lock_h_q == {3{CHECKER_LOCK}} |=> RDATA[11] == $past(CHECKER_LOCK))
    else $error("lock bit wrong");
  a_frame_len:
    assert property ($fell(GEN_TX_VALID) |-> run_q == pbl_pkg::FRAME_SHORT ||
      run_q == pbl_pkg::FRAME_LONG) else $error("frame length wrong");
  a_rdata_idle: // read port rests at zero
    assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside answer");
endmodule // pbl_regs_chk

bind pbl_regs pbl_regs_chk u_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .CHECKER_LOCK(CHECKER_LOCK), .IRQ_EVENT(IRQ_EVENT),
  .IRQ_PIN(IRQ_PIN), .GEN_TX_VALID(GEN_TX_VALID),
  .DOWNSHIFT_CFG(DOWNSHIFT_CFG), .LOOP_CFG(LOOP_CFG)
);

// [verification/pbl_regs_tb.sv]
// bench: random and corner register traffic for the phy test registers
`timescale 1ns/1ps
module phy_bist_loopback_config_regs_bench;
  logic        CLK_SYS, RST, WR, RD, IRQ_EVENT, IRQ_PIN, GEN_TX_VALID;
  logic        RX_ERR_EVENT, CHECKER_LOCK, SCR_LEGACY_MASTER, SPEED_GIG;
  logic        SCR_LEGACY_SLAVE, CORE_NORMAL_POWER, SPEED_100;
  logic        STRAP_DOWNSHIFT, PAT_WRAP_PULSE, lost;
  logic [4:0]  ADDR;
  logic [15:0] WDATA, RDATA, d, r, e;
  int          seed = 45747;
  int          error_cnt = 0;
  int          tests_run = 0;
  pbl_pkg::pbl_ds_cfg_t DOWNSHIFT_CFG;
  pbl_pkg::pbl_loop_t   LOOP_CFG;
  pbl_regs uut (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .STRAP_DOWNSHIFT(STRAP_DOWNSHIFT),
    .RX_ERR_EVENT(RX_ERR_EVENT), .CHECKER_LOCK(CHECKER_LOCK),
    .SCR_LEGACY_MASTER(SCR_LEGACY_MASTER), .SCR_LEGACY_SLAVE(SCR_LEGACY_SLAVE),
    .CORE_NORMAL_POWER(CORE_NORMAL_POWER), .SPEED_GIG(SPEED_GIG),
    .SPEED_100(SPEED_100), .IRQ_EVENT(IRQ_EVENT), .IRQ_PIN(IRQ_PIN),
    .GEN_TX_VALID(GEN_TX_VALID), .PAT_WRAP_PULSE(PAT_WRAP_PULSE),
    .DOWNSHIFT_CFG(DOWNSHIFT_CFG), .LOOP_CFG(LOOP_CFG));
  //////////////////////////////////////////////////////////////////////////
  // 125 MHz system clock
  initial
  begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end
  // a strobe still high costs one gap edge, so no signal is set twice
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    if (WR === 1'b1) @(posedge CLK_SYS);
    ADDR  <= a;
    WDATA <= v;
    WR    <= 1'b1;
    @(posedge CLK_SYS);
    #1 WR <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    if (RD === 1'b1) @(posedge CLK_SYS);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK_SYS);
    #1 v = RDATA;
    RD <= 1'b0;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // length of the next burst; zero if none comes
  task automatic frame(output logic [15:0] n);
    int k;
    n = 16'h0000;
    k = 0;
    while (GEN_TX_VALID !== 1'b1 && k < 3000)
    begin
      @(posedge CLK_SYS);
      #1 k++;
    end
    while (GEN_TX_VALID === 1'b1)
    begin
      @(posedge CLK_SYS);
      #1 n++;
    end
  endtask
  task automatic test_done;
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard, well above the expected run
  initial
  begin
    repeat (40000) @(posedge CLK_SYS);
    error_cnt++;
    test_done;
  end
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    {WR, RD, IRQ_EVENT, RX_ERR_EVENT, CHECKER_LOCK, lost} = 6'h00;
    {SCR_LEGACY_MASTER, SCR_LEGACY_SLAVE, CORE_NORMAL_POWER} = 3'h0;
    {SPEED_GIG, SPEED_100, STRAP_DOWNSHIFT} = 3'h3;
    ADDR = 5'h00;
    WDATA = 16'h0000;
    RST = 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (5) @(posedge CLK_SYS);
    // reset values, strap high lands in the enable bit
    rd(pbl_pkg::ADDR_CONFIG_TWO, r);
    chk(r, 16'h2B47);
    rd(pbl_pkg::ADDR_SELF_TEST, r);
    chk(r, 16'h0000);
    rd(5'h10, r);
    chk(r, 16'h0000);
    // every retry code, random other bits, polarity seen on the pin
    for (int i = 0; i < 4; i++)
    begin
      d = $random(seed);
      d[11:10] = i[1:0];
      wr(pbl_pkg::ADDR_CONFIG_TWO, d);
      rd(pbl_pkg::ADDR_CONFIG_TWO, r);
      chk(r, (d & 16'h2F40) | 16'h0007);
      IRQ_EVENT <= $random(seed);
      repeat (3) @(posedge CLK_SYS);
      #1 chk({12'h000, DOWNSHIFT_CFG.retry_limit}, 16'h0001 << i);
      chk({15'h0000, IRQ_PIN}, {15'h0000, IRQ_EVENT ^ d[13]});
    end
    // every loop point; coding loop cleared in the same write that changes the loop point
    for (int i = 0; i < 4; i++)
    begin
      e = 16'h0004 << i;
      d = ($random(seed) & 16'hE0C0) | e;
      wr(pbl_pkg::ADDR_SELF_TEST, d);
      wr(pbl_pkg::ADDR_SELF_TEST, d | i[1:0]);
      rd(pbl_pkg::ADDR_SELF_TEST, r);
      chk(r, d & ~{8'h00, i != 3, i != 0, 6'h00} | i[1:0]);
      chk({12'h000, LOOP_CFG.loop_point}, {12'h000, e[5:2]});
      chk({12'h000, LOOP_CFG.post_mlt, LOOP_CFG.pre_mlt, LOOP_CFG.pre_scr,
        LOOP_CFG.gig_pre_dsp}, {12'h000, i == 3, i == 2, i == 1, 1'b0});
    end
    SPEED_GIG <= 1'b1;
    SPEED_100 <= 1'b0;
    repeat (4) @(posedge CLK_SYS);
    #1 wr(pbl_pkg::ADDR_SELF_TEST, 16'h0021);
    repeat (3) @(posedge CLK_SYS);
    #1 chk({15'h0000, LOOP_CFG.gig_pre_dsp}, 16'h0001);
    wr(pbl_pkg::ADDR_SELF_TEST, 16'h0020);
    // five error events, then a write clears the tally
    repeat (5)
    begin
      RX_ERR_EVENT <= 1'b1;
      repeat (4) @(posedge CLK_SYS);
      RX_ERR_EVENT <= 1'b0;
      repeat (4) @(posedge CLK_SYS);
    end
    #1 rd(pbl_pkg::ADDR_RX_ERR, r);
    chk(r, 16'h0005);
    d = $random(seed);
    wr(pbl_pkg::ADDR_RX_ERR, d);
    rd(pbl_pkg::ADDR_RX_ERR, r);
    chk(r, 16'h0000);
    // status levels; lock first rises, then drops
    for (int i = 0; i < 6; i++)
    begin
      d = $random(seed);
      if (i < 2) d[0] = ~i[0];
      lost = lost | (CHECKER_LOCK & ~d[0]);
      CHECKER_LOCK <= d[0];
      SCR_LEGACY_MASTER <= d[1];
      SCR_LEGACY_SLAVE <= d[2];
      CORE_NORMAL_POWER <= d[3];
      repeat (5) @(posedge CLK_SYS);
      #1 rd(pbl_pkg::ADDR_STATUS_TWO, r);
      chk(r, {4'h0, d[0], lost, 1'b0, d[1], d[2], d[3], 6'h00});
      lost = 1'b0;
    end
    // constant payload: one frame only, short then long, busy while sending
    wr(pbl_pkg::ADDR_SELF_TEST, 16'h3000);
    frame(r);
    chk(r, 16'h0040);
    rd(pbl_pkg::ADDR_STATUS_TWO, r);
    chk(r & 16'h0200, 16'h0000);
    frame(r);
    chk(r, 16'h0000);
    wr(pbl_pkg::ADDR_SELF_TEST, 16'h0000);
    wr(pbl_pkg::ADDR_SELF_TEST, 16'h1000);
    frame(r);
    chk(r, 16'h05EE);
    wr(pbl_pkg::ADDR_SELF_TEST, 16'h0000);
    wr(pbl_pkg::ADDR_SELF_TEST, 16'h1000);
    repeat (20) @(posedge CLK_SYS);
    #1 rd(pbl_pkg::ADDR_STATUS_TWO, r);
    chk(r & 16'h0200, 16'h0200);
    repeat (1600) @(posedge CLK_SYS);
    #1 wr(pbl_pkg::ADDR_SELF_TEST, 16'h0000);
    // pattern payload repeats until the enable drops
    wr(pbl_pkg::ADDR_SELF_TEST, 16'hF000);
    frame(r);
    chk(r, 16'h0040);
    frame(r);
    chk(r, 16'h0040);
    wr(pbl_pkg::ADDR_SELF_TEST, 16'hC000);
    repeat (200) @(posedge CLK_SYS);
    #1 frame(r);
    chk(r, 16'h0000);
    test_done;
  end
endmodule // phy_bist_loopback_config_regs_bench
